// *** rtl/pin_redirect_consts.vh ***
/*
 * register indices, field positions, reset values and codes for the
 * alternate-function pin redirect block.
 * assumes: included by its bare name from the design file only.
 */
`ifndef PIN_REDIRECT_CONSTS_VH
`define PIN_REDIRECT_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_AUX0 10'h0a1
`define IDX_AUX1 10'h0a2
`define IDX_AUX2 10'h0a3
`define IDX_AUX3 10'h0a4
`define IDX_CTRL 10'h0a5
`define IDX_STAT 10'h0a6

// reset values and read masks
`define AUX_RST 8'h00
`define CTRL_RST 5'h00
`define AUX2_RMASK 8'hcf

// field positions, aux_route_control_0..3
`define F_P60 7:6
`define F_PIN44_45_FUNCTION_SELECT 3:2
`define F_KBI 7:6
`define B_SPI 5
`define F_S1 4:3
`define B_T01 2
`define B_ALEPOL 7
`define B_ADDRESS_OUT_ENABLE 6
`define B_ALEPS 3
`define F_TWI 2:1
`define B_T2 0

// field positions, extra control register
`define F_CLKSRC 1:0
`define F_EXT_MEMORY_INTERFACE_FIELD 3:2
`define B_S1UP 4

// system clock source codes
`define CLK_FAST_RC 2'b00
`define CLK_SLOW_RC 2'b01
`define CLK_XTAL 2'b10
`define CLK_EXT 2'b11

// codes of the selector fields
`define EXT_MEMORY_INTERFACE_FIELD_ADDR 2'b11
`define P60_GPIO 2'b00
`define P60_MCK 2'b01
`define P60_DIV2 2'b10
`define P60_DIV4 2'b11
`define P4_UART0 2'b01
`define P4_TMR01 2'b10
`define P4_TMR2 2'b11

// flat pin index of port p bit b
`define PIN(p, b) ((p) * 8 + (b))

`endif

// *** rtl/pin_redirect.v ***
/*
 * alternate-function pin redirect: steers peripheral signals onto
 * default or relocated port pins, plus the pin 6.0 clock functions,
 * the address latch strobe and external memory pins. apb slave.
 * assumes: one clock core_clk, synchronous inputs, pins flattened as
 * index port*8+bit, a gpio block supplying latch and output enables.
 */
`timescale 1ns/10ps
`include "pin_redirect_consts.vh"

// What this block does
// - zero fields give default pins
// - pin 6.0 selector only under rc osc
// - crystal mode takes pins 6.0 and 6.1
// - external clock mode: pin 6.0 input only
// - pin 6.0: gpio, clock, half, quarter
// - pins 4.4/4.5 two-bit function select
// - keypad inputs from four pin groups
// - spi pin group select
// - uart1 two-bit pin select, plus port 7 override bit
// - timer 0/1 pins 3.4/3.5 or 5.5/5.6
// - latch strobe polarity bit
// - address out on ports 5/6/7
// - latch strobe on 4.6 or 4.7
// - two-wire pins, four choices
// - timer 2 on pins 1.0/1.1
// - write/read strobes on 3.6/3.7
// - port 2 carries upper address/data
// - counter array on port 2
// - reset input active high
module pin_redirect (
    input  wire        core_clk,          // system clock
    input  wire        rst,               // sync reset, high
    input  wire        psel,              // apb select
    input  wire        penable,           // apb enable
    input  wire        pwrite,            // apb direction
    input  wire [11:0] paddr,             // apb byte address
    input  wire [31:0] pwdata,            // apb write data
    output wire [31:0] prdata,            // apb read data
    output wire        pready,            // apb ready
    output wire        pslverr,           // apb error
    input  wire [63:0] pin_in,            // pad levels
    output wire [63:0] pin_out,           // pad drive
    output wire [63:0] pin_oe_n,          // pad enable, low drives
    input  wire [63:0] gpio_out,          // gpio latch
    input  wire [63:0] gpio_oe_n,         // gpio enable, low drives
    input  wire        uart0_tx_out,      // uart0 transmit
    input  wire        uart0_tx_oe_n,     // uart0 transmit enable
    output reg         uart0_rx_in,       // uart0 receive
    input  wire        uart1_tx_out,      // uart1 transmit
    input  wire        uart1_tx_oe_n,     // uart1 transmit enable
    output wire        uart1_rx_in,       // uart1 receive
    input  wire [2:0]  tmr_cko_out,       // timer 0..2 clock out
    input  wire [2:0]  tmr_cko_oe_n,      // timer clock out enable
    output reg  [2:0]  tmr_in,            // timer 0..2 input
    output reg         tmr2_ex_in,        // timer 2 control input
    input  wire [5:0]  spi_out,           // ss,mosi,miso,sck,d2,d3
    input  wire [5:0]  spi_oe_n,          // spi line enables
    output reg  [5:0]  spi_in,            // spi line levels
    input  wire [1:0]  twi_out,           // scl, sda drive
    input  wire [1:0]  twi_oe_n,          // scl, sda enables
    output wire [1:0]  twi_in,            // scl, sda levels
    output reg  [7:0]  keypad_in,         // keypad interrupt inputs
    input  wire [5:0]  cex_out,           // counter module outputs
    input  wire [5:0]  cex_oe_n,          // counter module enables
    output wire [5:0]  cex_in,            // counter module inputs
    output wire        eci_in,            // counter array ext clock
    input  wire        ext_mem_cycle,     // external memory access
    input  wire [15:0] ext_addr,          // external address
    input  wire [7:0]  ext_ad_hi_out,     // upper address/data out
    input  wire        ext_ad_hi_oe_n,    // upper bus enable
    output wire [7:0]  ext_ad_hi_in,      // upper bus levels
    input  wire        ext_write_strobe,  // write strobe level
    input  wire        ext_read_strobe,   // read strobe level
    input  wire        ale,               // latch strobe, high active
    output wire        crystal_enable,    // crystal pins dedicated
    output wire        ext_clock_in       // external clock input
);

    reg  [7:0]  aux0_q;
    reg  [7:0]  aux1_q;
    reg  [7:0]  aux2_q;
    reg  [7:0]  aux3_q;
    reg  [4:0]  ctrl_q;
    reg  [31:0] prdata_q;
    reg  [1:0]  div_q;
    reg  [63:0] pin_out_q;
    reg  [63:0] pin_oe_n_q;
    reg  [63:0] alt_sel;
    reg  [63:0] alt_out;
    reg  [63:0] alt_oe_n;
    reg         fwd_clk;
    reg  [7:0]  rd_mux;
    integer     k;
    integer     j;
    integer     t01_base;
    integer     twi_base;
    integer     s1_rx;
    integer     s1_tx;
    integer     ale_pin;

    wire [9:0]  idx         = paddr[11:2];
    wire        setup       = psel & ~penable;
    wire        access      = psel & penable;
    wire [1:0]  clk_src     = ctrl_q[`F_CLKSRC];
    wire        internal    = (clk_src == `CLK_FAST_RC) | (clk_src == `CLK_SLOW_RC);
    wire        crystal     = (clk_src == `CLK_XTAL);
    wire        ext_clk     = (clk_src == `CLK_EXT);
    wire [1:0]  p60_sel     = internal ? aux0_q[`F_P60] : `P60_GPIO;
    wire [1:0]  pin44_45_function_select        = aux0_q[`F_PIN44_45_FUNCTION_SELECT];
    wire        addr_active = ext_mem_cycle & aux2_q[`B_ADDRESS_OUT_ENABLE]
                              & (ctrl_q[`F_EXT_MEMORY_INTERFACE_FIELD] == `EXT_MEMORY_INTERFACE_FIELD_ADDR);
    wire        hit         = (idx >= `IDX_AUX0) & (idx <= `IDX_STAT);

    // route one pin; grab takes it even while the source is released
    task route;
        input integer i;
        input         o;
        input         oen;
        input         grab;
        begin
            if (grab | ~oen)
            begin
                alt_sel[i]  = 1'b1;
                alt_out[i]  = o;
                alt_oe_n[i] = oen;
            end
        end
    endtask

    // spi line k on its pin group
    function integer spi_pin;
        input         sel;
        input integer n;
        begin
            case (n)
                0:       spi_pin = sel ? `PIN(4, 3) : `PIN(1, 4);
                1:       spi_pin = sel ? `PIN(4, 2) : `PIN(1, 5);
                2:       spi_pin = sel ? `PIN(4, 1) : `PIN(1, 6);
                3:       spi_pin = sel ? `PIN(4, 0) : `PIN(1, 7);
                4:       spi_pin = sel ? `PIN(3, 6) : `PIN(5, 3);
                default: spi_pin = sel ? `PIN(3, 7) : `PIN(5, 4);
            endcase
        end
    endfunction

    // pin numbers picked by the selector fields
    always @*
    begin
        t01_base = aux1_q[`B_T01] ? `PIN(5, 5) : `PIN(3, 4);
        if (pin44_45_function_select == `P4_TMR01)
            t01_base = `PIN(4, 4);
        case (aux3_q[`F_TWI])
            2'b00:   twi_base = `PIN(4, 0);
            2'b01:   twi_base = `PIN(6, 0);
            2'b10:   twi_base = `PIN(3, 0);
            default: twi_base = `PIN(3, 4);
        endcase
        case (aux1_q[`F_S1])
            2'b00:   s1_rx = `PIN(1, 2);
            2'b01:   s1_rx = `PIN(3, 2);
            2'b10:   s1_rx = `PIN(0, 6);
            default: s1_rx = `PIN(0, 0);
        endcase
        s1_tx = (aux1_q[`F_S1] == 2'b11) ? `PIN(0, 5) : s1_rx + 1;
        if (ctrl_q[`B_S1UP])
        begin
            s1_rx = `PIN(7, 0);
            s1_tx = `PIN(7, 1);
        end
        ale_pin = aux3_q[`B_ALEPS] ? `PIN(4, 7) : `PIN(4, 6);
    end

    // output routing; later calls win, so lowest priority goes first
    always @*
    begin
        alt_sel  = 64'h0000_0000_0000_0000;
        alt_out  = 64'h0000_0000_0000_0000;
        alt_oe_n = 64'hffff_ffff_ffff_ffff;
        fwd_clk  = 1'b0;
        // counter array modules on 2.2..2.7
        for (k = 0; k < 6; k = k + 1)
            route(`PIN(2, 2) + k, cex_out[k], cex_oe_n[k], 1'b0);
        // uart0 transmit: default 3.1 or relocated 4.5
        if (pin44_45_function_select == `P4_UART0)
            route(`PIN(4, 5), uart0_tx_out, uart0_tx_oe_n, 1'b0);
        else
            route(`PIN(3, 1), uart0_tx_out, uart0_tx_oe_n, 1'b0);
        // timer 0/1 clock outputs
        for (k = 0; k < 2; k = k + 1)
            route(t01_base + k, tmr_cko_out[k], tmr_cko_oe_n[k], 1'b0);
        // timer 2 clock output
        if (pin44_45_function_select == `P4_TMR2)
            route(`PIN(4, 5), tmr_cko_out[2], tmr_cko_oe_n[2], 1'b0);
        else if (!aux3_q[`B_T2])
            route(`PIN(1, 0), tmr_cko_out[2], tmr_cko_oe_n[2], 1'b0);
        route(s1_tx, uart1_tx_out, uart1_tx_oe_n, 1'b0);
        for (k = 0; k < 6; k = k + 1)
            route(spi_pin(aux1_q[`B_SPI], k), spi_out[k], spi_oe_n[k], 1'b0);
        for (k = 0; k < 2; k = k + 1)
            route(twi_base + k, twi_out[k], twi_oe_n[k], 1'b0);
        // external memory takes its pins outright during a cycle
        if (ext_mem_cycle)
        begin
            for (k = 0; k < 8; k = k + 1)
                route(`PIN(2, 0) + k, ext_ad_hi_out[k], ext_ad_hi_oe_n, 1'b1);
            route(`PIN(3, 6), ext_write_strobe, 1'b0, 1'b1);
            route(`PIN(3, 7), ext_read_strobe, 1'b0, 1'b1);
            route(ale_pin, ale ^ aux2_q[`B_ALEPOL], 1'b0, 1'b1);
        end
        // address bytes onto the spare ports
        if (addr_active)
        begin
            for (k = 0; k < 8; k = k + 1)
                route(`PIN(5, 0) + k, ext_addr[k], 1'b0, 1'b1);
            for (k = 0; k < 6; k = k + 1)
                route(`PIN(6, 2) + k, ext_addr[10 + k], 1'b0, 1'b1);
            route(`PIN(7, 0), ext_addr[8], 1'b0, 1'b1);
            route(`PIN(7, 1), ext_addr[9], 1'b0, 1'b1);
        end
        // clock pins: top priority, nothing may fight the oscillator
        if (crystal)
        begin
            route(`PIN(6, 0), 1'b0, 1'b1, 1'b1);
            route(`PIN(6, 1), 1'b0, 1'b1, 1'b1);
        end
        else if (ext_clk)
            route(`PIN(6, 0), 1'b0, 1'b1, 1'b1);
        else
        begin
            // pin keeps the gpio output mode in every clock setting
            case (p60_sel)
                `P60_MCK:
                begin
                    route(`PIN(6, 0), 1'b0, gpio_oe_n[`PIN(6, 0)], 1'b1);
                    fwd_clk = 1'b1;
                end
                `P60_DIV2: route(`PIN(6, 0), div_q[0], gpio_oe_n[`PIN(6, 0)], 1'b1);
                `P60_DIV4: route(`PIN(6, 0), div_q[1], gpio_oe_n[`PIN(6, 0)], 1'b1);
                default:   fwd_clk = 1'b0;
            endcase
        end
    end

    // per-pin output flops: routed function beats the gpio latch
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1)
        begin : g_pin
            always @(posedge core_clk)
            begin
                if (rst)
                begin
                    pin_out_q[g]  <= 1'b0;
                    pin_oe_n_q[g] <= 1'b1;
                end
                else
                begin
                    pin_out_q[g]  <= alt_sel[g] ? alt_out[g] : gpio_out[g];
                    pin_oe_n_q[g] <= alt_sel[g] ? alt_oe_n[g] : gpio_oe_n[g];
                end
            end
            // full-rate clock cannot pass a flop, so it is forwarded
            if (g == `PIN(6, 0))
            begin : g_clk
                assign pin_out[g] = fwd_clk ? core_clk : pin_out_q[g];
            end
            else
            begin : g_dat
                assign pin_out[g] = pin_out_q[g];
            end
            assign pin_oe_n[g] = pin_oe_n_q[g];
        end
    endgenerate

    // peripheral inputs picked from the selected pins
    always @*
    begin
        uart0_rx_in = pin_in[(pin44_45_function_select == `P4_UART0) ? `PIN(4, 4) : `PIN(3, 0)];
        tmr_in[0]   = pin_in[t01_base];
        tmr_in[1]   = pin_in[t01_base + 1];
        // timer 2 reads zero unless on pins 4.5/4.4 or, with B_T2 clear, on 1.0/1.1
        tmr_in[2]   = 1'b0;
        tmr2_ex_in  = 1'b0;
        if (pin44_45_function_select == `P4_TMR2)
        begin
            tmr_in[2]  = pin_in[`PIN(4, 5)];
            tmr2_ex_in = pin_in[`PIN(4, 4)];
        end
        else if (!aux3_q[`B_T2])
        begin
            tmr_in[2]  = pin_in[`PIN(1, 0)];
            tmr2_ex_in = pin_in[`PIN(1, 1)];
        end
        // own loop index, so the two routing processes never wake each other
        for (j = 0; j < 6; j = j + 1)
            spi_in[j] = pin_in[spi_pin(aux1_q[`B_SPI], j)];
        case (aux1_q[`F_KBI])
            2'b00:   keypad_in = pin_in[7:0];
            2'b01:   keypad_in = pin_in[23:16];
            2'b10:   keypad_in = pin_in[47:40];
            default: keypad_in = {pin_in[35:32], pin_in[31:28]};
        endcase
    end

    assign uart1_rx_in    = pin_in[s1_rx];
    assign twi_in         = {pin_in[twi_base + 1], pin_in[twi_base]};
    assign cex_in         = pin_in[23:18];
    assign eci_in         = pin_in[`PIN(2, 1)];
    assign ext_ad_hi_in   = pin_in[23:16];
    assign crystal_enable = crystal;
    assign ext_clock_in   = ext_clk & pin_in[`PIN(6, 0)];

    // free-running divider for the half and quarter clock outputs
    always @(posedge core_clk)
    begin
        if (rst)
            div_q <= 2'b00;
        else
            div_q <= div_q + 2'b01;
    end

    // register writes take effect at the access edge
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            aux0_q <= `AUX_RST;
            aux1_q <= `AUX_RST;
            aux2_q <= `AUX_RST;
            aux3_q <= `AUX_RST;
            ctrl_q <= `CTRL_RST;
        end
        else if (access & pwrite)
        begin
            case (idx)
                `IDX_AUX0: aux0_q <= pwdata[7:0];
                `IDX_AUX1: aux1_q <= pwdata[7:0];
                `IDX_AUX2: aux2_q <= pwdata[7:0];
                `IDX_AUX3: aux3_q <= pwdata[7:0];
                `IDX_CTRL: ctrl_q <= pwdata[4:0];
                default:   ctrl_q <= ctrl_q;
            endcase
        end
    end

    // read mux; status shows the live routing state
    always @*
    begin
        case (idx)
            `IDX_AUX0: rd_mux = aux0_q;
            `IDX_AUX1: rd_mux = aux1_q;
            `IDX_AUX2: rd_mux = aux2_q & `AUX2_RMASK;
            `IDX_AUX3: rd_mux = aux3_q;
            `IDX_CTRL: rd_mux = {3'b000, ctrl_q};
            `IDX_STAT: rd_mux = {2'b00, ext_mem_cycle, addr_active, ext_clk, crystal, p60_sel};
            default:   rd_mux = 8'h00;
        endcase
    end

    // read data captured in the setup cycle, so no wait state is needed
    always @(posedge core_clk)
    begin
        if (rst)
            prdata_q <= 32'h0000_0000;
        else if (setup)
            prdata_q <= {24'h00_0000, rd_mux};
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

endmodule // pin_redirect

// *** tb/pin_redirect_chk.sv ***
/* port assertions for the pin redirect block.
   assumes: bound to pin_redirect, one clock, sync reset. */
`timescale 1ns/10ps
module pin_redirect_chk (
    input wire        core_clk,      // clock
    input wire        rst,           // reset, high
    input wire        psel,          // apb select
    input wire        penable,       // apb enable
    input wire        pwrite,        // apb direction
    input wire [11:0] paddr,         // apb address
    input wire [31:0] pwdata,        // apb write data
    input wire        pready,        // apb ready
    input wire        pslverr,       // apb error
    input wire [63:0] pin_in,        // pad levels
    input wire [63:0] pin_out,       // pad drive
    input wire [63:0] pin_oe_n,      // pad enables
    input wire        uart1_rx_in,   // uart1 receive
    input wire [5:0]  spi_out,       // spi drive
    input wire [5:0]  spi_oe_n,      // spi enables
    input wire [1:0]  twi_in,        // two-wire levels
    input wire [7:0]  keypad_in,     // keypad inputs
    input wire [5:0]  cex_in,        // counter inputs
    input wire        eci_in,        // counter clock
    input wire        ext_mem_cycle, // memory access
    input wire [15:0] ext_addr,      // memory address
    input wire [7:0]  ext_ad_hi_in,  // upper bus levels
    input wire        ale            // latch strobe
);
    reg [7:0] a1_q, a2_q, a3_q;
    reg [4:0] c_q;
    wire      wr = psel && penable && pwrite;
    wire [9:0] ix = paddr[11:2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // shadow copies of the routing fields, taken at the write edge
    always @(posedge core_clk)
    begin
        a1_q <= rst ? 8'h00 : (wr && ix == 10'h0a2) ? pwdata[7:0] : a1_q;
        a2_q <= rst ? 8'h00 : (wr && ix == 10'h0a3) ? pwdata[7:0] : a2_q;
        a3_q <= rst ? 8'h00 : (wr && ix == 10'h0a4) ? pwdata[7:0] : a3_q;
        c_q  <= rst ? 5'h00 : (wr && ix == 10'h0a5) ? pwdata[4:0] : c_q;
    end
    sequence spi_alt_s;
        !spi_oe_n[0] && a1_q[5];
    endsequence
    sequence addr_out_s;
        ext_mem_cycle && a2_q[6] && c_q[3:2] == 2'b11;
    endsequence
    pads_reset_a: assert property (disable iff (1'b0) rst |=> pin_oe_n == {64{1'b1}})
        else $error("pads not released in reset");
    bus_ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    bus_error_a: assert property (psel && penable |-> pslverr == (ix < 10'h0a1 || ix > 10'h0a6))
        else $error("error flag wrong for address");
    port2_in_a: assert property (cex_in == pin_in[23:18] && eci_in == pin_in[17] && ext_ad_hi_in == pin_in[23:16])
        else $error("port 2 input routing wrong");
    keypad_grp_a: assert property (keypad_in == (a1_q[7:6] == 2'b00 ? pin_in[7:0] : a1_q[7:6] == 2'b01 ?
        pin_in[23:16] : a1_q[7:6] == 2'b10 ? pin_in[47:40] : {pin_in[35:32], pin_in[31:28]}))
        else $error("keypad group wrong");
    twi_pins_a: assert property (!c_q[1] |-> twi_in[0] == (a3_q[2:1] == 2'b00 ? pin_in[32] : a3_q[2:1] == 2'b01 ?
        pin_in[48] : a3_q[2:1] == 2'b10 ? pin_in[24] : pin_in[28]))
        else $error("two-wire clock pin wrong");
    uart1_pins_a: assert property (uart1_rx_in == (c_q[4] ? pin_in[56] : a1_q[4:3] == 2'b00 ? pin_in[10] :
        a1_q[4:3] == 2'b01 ? pin_in[26] : a1_q[4:3] == 2'b10 ? pin_in[6] : pin_in[0]))
        else $error("uart1 receive pin wrong");
    spi_moved_a: assert property (spi_alt_s |=> pin_out[35] == $past(spi_out[0]) && !pin_oe_n[35])
        else $error("spi select not on moved pin");
    ale_place_a: assert property (ext_mem_cycle |=>
        ($past(a3_q[3]) ? pin_out[39] : pin_out[38]) == $past(ale ^ a2_q[7]))
        else $error("latch strobe pin or polarity wrong");
    addr_out_a: assert property (addr_out_s |=> pin_out[47:40] == $past(ext_addr[7:0]) &&
        pin_out[55:50] == $past(ext_addr[15:10]) && pin_out[57:56] == $past(ext_addr[9:8]))
        else $error("address not on ports");
endmodule // pin_redirect_chk

bind pin_redirect pin_redirect_chk chk_i (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe_n, .uart1_rx_in, .spi_out, .spi_oe_n, .twi_in, .keypad_in, .cex_in,
    .eci_in, .ext_mem_cycle, .ext_addr, .ext_ad_hi_in, .ale);

// *** tb/pad_model.sv ***
/* far side of the pads: board levels meet the block's drive.
   assumes: released pads show the board level, as with a pull. */
`timescale 1ns/10ps
module pad_model (
    input  wire [63:0] pin_out,  // block drive
    input  wire [63:0] pin_oe_n, // low drives
    input  wire [63:0] ext_lvl,  // board level
    output wire [63:0] pin_in    // level at pad
);
    // a driven pad reads back its own drive, never the stale board value
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule // pad_model

// *** tb/pin_redirect_test.sv ***
/* self-checking bench for the pin redirect block over apb.
   assumes: pad_model on the pads, checker bound to the design. */
`timescale 1ns/10ps
module pin_redirect_test;
    reg        core_clk, rst, psel, penable, pwrite, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [63:0] gpio_out, gpio_oe_n, ext_lvl;
    reg        uart0_tx_out, uart0_tx_oe_n, uart1_tx_out, uart1_tx_oe_n, ale;
    reg        ext_mem_cycle, ext_ad_hi_oe_n, ext_write_strobe, ext_read_strobe, prev;
    reg [2:0]  tmr_cko_out, tmr_cko_oe_n;
    reg [5:0]  spi_out, spi_oe_n, cex_out, cex_oe_n;
    reg [1:0]  twi_out, twi_oe_n;
    reg [15:0] ext_addr;
    reg [7:0]  ext_ad_hi_out;
    wire [31:0] prdata;
    wire [63:0] pin_in, pin_out, pin_oe_n;
    wire        pready, pslverr, uart0_rx_in, uart1_rx_in, tmr2_ex_in, eci_in, crystal_enable, ext_clock_in;
    wire [2:0]  tmr_in;
    wire [5:0]  spi_in, cex_in;
    wire [1:0]  twi_in;
    wire [7:0]  keypad_in, ext_ad_hi_in;
    integer     error_cnt = 0, n_tests = 0, i, t;
    integer     rxp[5] = '{10, 26, 6, 0, 56};
    integer     txp[5] = '{11, 27, 7, 5, 57};
    integer     sclp[4] = '{32, 48, 24, 28};
    reg [7:0]   kexp[4] = '{8'hef, 8'hab, 8'h45, 8'h78};
    reg [7:0]   fexp[5] = '{8'ha5, 8'h84, 8'h91, 8'h87, 8'h61};
    localparam [63:0] PAT = 64'h0123_4567_89ab_cdef;

    pin_redirect uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe_n, .gpio_out, .gpio_oe_n, .uart0_tx_out, .uart0_tx_oe_n, .uart0_rx_in,
        .uart1_tx_out, .uart1_tx_oe_n, .uart1_rx_in, .tmr_cko_out, .tmr_cko_oe_n, .tmr_in, .tmr2_ex_in,
        .spi_out, .spi_oe_n, .spi_in, .twi_out, .twi_oe_n, .twi_in, .keypad_in, .cex_out, .cex_oe_n, .cex_in,
        .eci_in, .ext_mem_cycle, .ext_addr, .ext_ad_hi_out, .ext_ad_hi_oe_n, .ext_ad_hi_in, .ext_write_strobe,
        .ext_read_strobe, .ale, .crystal_enable, .ext_clock_in);
    pad_model pads (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    task chk(input [63:0] seen, input [63:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; held until ready is seen at an edge
    task apb(input [11:0] a, input w, input [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // pads are registered: let the config edge and the pad edge pass
    task settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end

    initial
    begin
        {core_clk, psel, penable, pwrite, uart0_tx_out, uart1_tx_out, ale, ext_mem_cycle} = 8'h00;
        {ext_write_strobe, ext_read_strobe, tmr_cko_out, twi_out, cex_out, spi_out} = 0;
        {uart0_tx_oe_n, uart1_tx_oe_n, ext_ad_hi_oe_n, tmr_cko_oe_n, spi_oe_n, cex_oe_n, twi_oe_n} = '1;
        {rst, paddr, pwdata, ext_addr, ext_ad_hi_out, gpio_out, ext_lvl} = {1'b1, 68'h0, PAT, PAT};
        gpio_oe_n = '1;
        repeat (12) @(posedge core_clk);
        chk(pin_oe_n, {64{1'b1}});
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin apb(12'h284 + 4 * i, 0, 0); chk(rd, 0); end
        for (i = 0; i < 5; i++) apb(12'h284 + 4 * i, 1, 32'hffff_ffff);
        for (i = 0; i < 5; i++) begin apb(12'h284 + 4 * i, 0, 0); chk(rd, i == 2 ? 8'hcf : i == 4 ? 8'h1f : 8'hff); end
        apb(12'h200, 0, 0);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        for (i = 0; i < 5; i++) apb(12'h284 + 4 * i, 1, 0);
        // default routing, then spi moved
        gpio_oe_n <= 0; spi_oe_n <= 0; spi_out <= 6'b10_1101; tmr_cko_oe_n <= 3'b011;
        settle;
        chk({pin_out[44:43], pin_out[15:12], pin_out[8], pin_out[63:45], pin_out[7:0]}, {6'b10_1101, 1'b0,
            PAT[63:45], PAT[7:0]});
        apb(12'h288, 1, 32'h0000_0020); settle;
        chk({pin_out[31:30], pin_out[32], pin_out[33], pin_out[34], pin_out[35], pin_out[15:12]}, 10'h2dc);
        @(posedge core_clk); spi_oe_n <= '1; gpio_oe_n <= '1; uart1_tx_oe_n <= 1'b0;
        for (i = 0; i < 5; i++) begin // uart1 placements
            apb(12'h288, 1, (i % 4) << 3); apb(12'h294, 1, i == 4 ? 32'h10 : 32'h0);
            ext_lvl <= ~(64'd1 << rxp[i]); settle;
            chk({uart1_rx_in, pin_oe_n[txp[i]], pin_out[txp[i]]}, 0);
        end
        apb(12'h294, 1, 0); uart1_tx_oe_n <= 1'b1; twi_oe_n <= 0; ext_lvl <= '1;
        for (i = 0; i < 4; i++) begin apb(12'h290, 1, i << 1); settle; chk({pin_oe_n[sclp[i]], pin_out[sclp[i]], twi_in[0]}, 0); end
        apb(12'h290, 1, 0); twi_oe_n <= '1; ext_lvl <= PAT;
        for (i = 0; i < 4; i++) begin apb(12'h288, 1, i << 6); settle; chk(keypad_in, kexp[i]); end
        apb(12'h288, 1, 0); gpio_oe_n <= 0; apb(12'h284, 1, 32'hc0); apb(12'h294, 1, 32'h2); settle;
        apb(12'h298, 0, 0); chk({rd, crystal_enable, pin_oe_n[49:48]}, {32'h04, 3'b111});
        apb(12'h294, 1, 32'h3); settle;
        apb(12'h298, 0, 0); chk({rd, ext_clock_in, pin_oe_n[48]}, {32'h08, 2'b11});
        apb(12'h294, 1, 0); gpio_oe_n <= 0;
        apb(12'h298, 0, 0); chk(rd, 32'h03);
        for (i = 0; i < 4; i++) begin // clock out on pin 6.0, looked at every half period
            apb(12'h284, 1, i == 0 ? 32'h00 : i == 1 ? 32'h80 : i == 2 ? 32'hc0 : 32'h40); settle;
            t = 0; prev = pin_out[48];
            repeat (16) begin @(core_clk); #1; t = t + (pin_out[48] !== prev); prev = pin_out[48]; end
            chk(t, i == 0 ? 0 : i == 1 ? 8 : i == 2 ? 4 : 16);
        end
        for (i = 0; i < 5; i++) begin // pins 4.4/4.5 functions, then timer 0/1 moved
            apb(12'h284, 1, (i % 4) << 2); apb(12'h288, 1, i == 4 ? 32'h4 : 32'h0);
            {uart0_tx_oe_n, tmr_cko_oe_n, tmr_cko_out} <= 7'h01; settle;
            chk({pin_out[46:45], pin_out[37:36], pin_out[29:28], pin_out[8], uart0_rx_in}, fexp[i]);
        end
        apb(12'h288, 1, 0);
        apb(12'h284, 1, 0); apb(12'h294, 1, 32'h0c); apb(12'h28c, 1, 32'hc0); apb(12'h290, 1, 32'h08);
        ext_mem_cycle <= 1'b1; ext_addr <= 16'ha5c3; ale <= 1'b1; ext_write_strobe <= 1'b1;
        ext_ad_hi_out <= 8'h3c; ext_ad_hi_oe_n <= 1'b0; settle;
        chk({pin_out[47:40], pin_out[55:50], pin_out[57:56], pin_out[39]}, {8'hc3, 6'b10_1001, 2'b01, 1'b0});
        chk({pin_out[31:30], pin_out[23:16]}, {2'b01, 8'h3c});
        apb(12'h28c, 1, 32'h40); apb(12'h294, 1, 32'h08); settle;
        chk({pin_out[39], pin_out[47:40]}, {1'b1, PAT[47:40]});
        ext_mem_cycle <= 1'b0;
        wrap_up;
    end
endmodule // pin_redirect_test
